// [core/pmp_pkg.sv]
// ---------------------------------------------------------------------------
// Summary of operation
// - low supply keeps every pulse output inactive
// - supply decision filtered with hysteresis against glitches
// - per phase multiply current by voltage sample
// - add three phase powers into total power
// - current high-pass removes offset before multiply
// - current path lag offsets high-pass phase lead
// - first-order smoothing of each phase product
// - accumulate total power, pulse at each threshold
// - calibration pulse uses much shorter accumulation
// - slow outputs use long, ripple-averaging accumulation
// - slow outputs carry active-high pulses
// - three select bits pick base scaling frequency
// - summing mode: arithmetic high, absolute low
// - negative flag for negative power any phase
// ---------------------------------------------------------------------------
package pmp_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SUP_RISE_NS = 10000;
  localparam int unsigned SUP_FALL_NS = 2000;
  localparam int unsigned SUP_RISE_CYC = (SUP_RISE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SUP_FALL_CYC = (SUP_FALL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOW_WIDTH_NS = 100000;
  localparam int unsigned SLOW_WIDTH_CYC = (SLOW_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CAL_WIDTH_NS = 1000;
  localparam int unsigned CAL_WIDTH_CYC = (CAL_WIDTH_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------------------
  // filter shifts and frequency scaling
  // ---------------------------------------------------------------------------
  localparam int unsigned HPF_SHIFT = 10;
  localparam int unsigned PHC_SHIFT = 6;
  localparam int unsigned LPF_SHIFT = 7;
  localparam int unsigned CAL_SHIFT = 7;
  localparam logic [47:0] THR_SCALE = 48'h4000_0000_0000;
  // base frequency in centihertz, index is {high select, low select, cal select}
  localparam logic [15:0] F_CHZ [8] = '{16'h007F, 16'h0077, 16'h01FD, 16'h01DD,
                                        16'h0773, 16'h0773, 16'h1DCD, 16'h003C};

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SLOW_CNT = 8'h08;
  localparam logic [7:0] REG_CAL_CNT = 8'h0C;
  localparam int unsigned CTRL_SUM_BIT = 0;
  localparam int unsigned CTRL_SEL_LO_BIT = 1;
  localparam int unsigned CTRL_SEL_HI_BIT = 2;
  localparam int unsigned CTRL_CAL_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h1;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][15:0] cur;
    logic [2:0][15:0] volt;
  } pmp_sample_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pmp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmp_apb_rsp_s;

  typedef enum logic [1:0] {
    SUP_LOW = 2'h0,
    SUP_RISE = 2'h1,
    SUP_GOOD = 2'h3,
    SUP_FALL = 2'h2
  } pmp_sup_e;

endpackage

// [core/pmp_power_to_freq.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module pmp_power_to_freq #(
  parameter int unsigned SLOW_WIDTH = pmp_pkg::SLOW_WIDTH_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pmp_pkg::pmp_apb_req_s apb_req,
  output pmp_pkg::pmp_apb_rsp_s apb_rsp,
  input wire logic sample_valid,
  input wire pmp_pkg::pmp_sample_s samples,
  input wire logic supply_above_trigger,
  output logic avg_power_pulse_first,
  output logic avg_power_pulse_second,
  output logic calibration_pulse_out,
  output logic negative_power_flag
);
  import pmp_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    pmp_apb_rsp_s rsp;
    logic [3:0] ctrl;
    logic [1:0] sync;
    pmp_sup_e sup;
    logic [11:0] sup_cnt;
    logic [2:0][31:0] dc;
    logic [2:0][16:0] prev;
    logic [2:0][43:0] lp;
    logic [2:0] neg;
    logic neg_out;
    logic [47:0] acc_s;
    logic [47:0] acc_c;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] wc;
    logic f1;
    logic f2;
    logic cf;
    logic [31:0] slow_cnt;
    logic [31:0] cal_cnt;
  } pmp_state_s;

  pmp_state_s st;
  pmp_state_s next_st;

  // ---------------------------------------------------------------------------
  // per-phase datapath
  // ---------------------------------------------------------------------------
  logic [47:0] thr_tab [8];
  logic signed [33:0] real_pw [3];
  logic [31:0] dc_nxt [3];
  logic [16:0] hp_nxt [3];
  logic [43:0] lp_nxt [3];

  // thresholds fold to constants; the division never reaches hardware
  for (genvar t = 0; t < 8; t++) begin : g_thr
    assign thr_tab[t] = THR_SCALE / 48'(F_CHZ[t]);
  end

  for (genvar g = 0; g < 3; g++) begin : g_ph
    logic signed [15:0] xi;
    logic signed [15:0] vi;
    logic signed [31:0] dc;
    logic signed [33:0] dc_err;
    logic signed [16:0] hp;
    logic signed [17:0] dh;
    logic signed [17:0] pc;
    logic signed [33:0] prod;
    logic signed [43:0] lp;
    assign xi = $signed(samples.cur[g]);
    assign vi = $signed(samples.volt[g]);
    assign dc = $signed(st.dc[g]);
    // offset tracker, fraction kept in the low 16 bits
    assign dc_err = $signed({xi, 16'h0000}) - dc;
    assign dc_nxt[g] = 32'(dc + (dc_err >>> HPF_SHIFT));
    assign hp = xi - $signed(dc[31:16]);
    // a small lag from the difference term cancels the high-pass lead
    assign dh = hp - $signed(st.prev[g]);
    assign pc = hp - (dh >>> PHC_SHIFT);
    assign hp_nxt[g] = hp;
    assign prod = pc * vi;
    // leaky integrator; gain of 2^shift is removed on the way out
    assign lp = $signed(st.lp[g]);
    assign lp_nxt[g] = 44'(lp + prod - (lp >>> LPF_SHIFT));
    assign real_pw[g] = 34'(lp >>> LPF_SHIFT);
  end

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  logic good;
  logic hit;
  logic [31:0] rdata;
  logic signed [35:0] tot;
  logic signed [35:0] mag;
  logic [47:0] add;
  logic [48:0] sum_s;
  logic [48:0] sum_c;
  logic [47:0] thr_s;
  logic [47:0] thr_c;
  logic fire_1;
  logic fire_2;
  logic fire_c;

  always_comb begin
    next_st = st;
    good = (st.sup == SUP_GOOD) || (st.sup == SUP_FALL);
    rdata = 32'h0000_0000;
    hit = 1'b1;
    tot = 36'sh0_0000_0000;
    add = 48'h0000_0000_0000;
    sum_s = 49'h0_0000_0000_0000;
    sum_c = 49'h0_0000_0000_0000;
    fire_1 = 1'b0;
    fire_2 = 1'b0;
    fire_c = 1'b0;
    thr_s = thr_tab[{st.ctrl[CTRL_SEL_HI_BIT], st.ctrl[CTRL_SEL_LO_BIT],
                     st.ctrl[CTRL_CAL_BIT]}];
    thr_c = thr_s >> CAL_SHIFT;

    // apb slave: one wait state, write lands at the edge pready is seen
    case (apb_req.paddr)
      REG_CTRL: rdata = {28'h000_0000, st.ctrl};
      REG_STATUS: rdata = {27'h000_0000, st.neg_out, st.neg, good};
      REG_SLOW_CNT: rdata = st.slow_cnt;
      REG_CAL_CNT: rdata = st.cal_cnt;
      default: hit = 1'b0;
    endcase
    next_st.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = !hit;
      next_st.rsp.prdata = hit ? rdata : 32'h0000_0000;
    end
    if (st.rsp.pready && apb_req.psel && apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == REG_CTRL) begin
      next_st.ctrl = apb_req.pwdata[3:0];
    end

    // supply filter: long qualify on rise, shorter on fall gives hysteresis
    next_st.sync = {st.sync[0], supply_above_trigger};
    case (st.sup)
      SUP_LOW: begin
        next_st.sup_cnt = 12'h000;
        if (st.sync[1]) begin
          next_st.sup = SUP_RISE;
        end
      end
      SUP_RISE: begin
        if (!st.sync[1]) begin
          next_st.sup = SUP_LOW;
          next_st.sup_cnt = 12'h000;
        end else if (st.sup_cnt == 12'(SUP_RISE_CYC - 1)) begin
          next_st.sup = SUP_GOOD;
          next_st.sup_cnt = 12'h000;
        end else begin
          next_st.sup_cnt = st.sup_cnt + 12'h001;
        end
      end
      SUP_GOOD: begin
        next_st.sup_cnt = 12'h000;
        if (!st.sync[1]) begin
          next_st.sup = SUP_FALL;
        end
      end
      SUP_FALL: begin
        if (st.sync[1]) begin
          next_st.sup = SUP_GOOD;
          next_st.sup_cnt = 12'h000;
        end else if (st.sup_cnt == 12'(SUP_FALL_CYC - 1)) begin
          next_st.sup = SUP_LOW;
          next_st.sup_cnt = 12'h000;
        end else begin
          next_st.sup_cnt = st.sup_cnt + 12'h001;
        end
      end
      default: begin
        next_st.sup = SUP_LOW;
        next_st.sup_cnt = 12'h000;
      end
    endcase

    // combine phases; absolute mode counts reversed phases as positive
    for (int k = 0; k < 3; k++) begin
      mag = real_pw[k][33] ? -36'(real_pw[k]) : 36'(real_pw[k]);
      tot = st.ctrl[CTRL_SUM_BIT] ? tot + 36'(real_pw[k]) : tot + mag;
    end
    // negative totals add nothing: the meter never counts backwards
    add = tot[35] ? 48'h0000_0000_0000 : {12'h000, tot};
    sum_s = {1'b0, st.acc_s} + {1'b0, add};
    sum_c = {1'b0, st.acc_c} + {1'b0, add};

    if (sample_valid) begin
      for (int k = 0; k < 3; k++) begin
        next_st.dc[k] = dc_nxt[k];
        next_st.prev[k] = hp_nxt[k];
        next_st.lp[k] = lp_nxt[k];
        next_st.neg[k] = real_pw[k][33];
      end
      next_st.neg_out = |next_st.neg;
      // slow path: whole threshold per pulse, second output half a period later
      if (sum_s >= {1'b0, thr_s}) begin
        fire_1 = 1'b1;
        next_st.acc_s = 48'(sum_s - {1'b0, thr_s});
      end else begin
        next_st.acc_s = sum_s[47:0];
      end
      fire_2 = (st.acc_s < (thr_s >> 1)) && (sum_s >= {2'b00, thr_s[47:1]});
      if (sum_c >= {1'b0, thr_c}) begin
        fire_c = 1'b1;
        next_st.acc_c = 48'(sum_c - {1'b0, thr_c});
      end else begin
        next_st.acc_c = sum_c[47:0];
      end
    end

    // fixed pulse widths; a new pulse restarts its width counter
    next_st.w1 = fire_1 ? 16'(SLOW_WIDTH) : (st.w1 != 16'h0000 ? st.w1 - 16'h0001 : st.w1);
    next_st.w2 = fire_2 ? 16'(SLOW_WIDTH) : (st.w2 != 16'h0000 ? st.w2 - 16'h0001 : st.w2);
    next_st.wc = fire_c ? 16'(CAL_WIDTH_CYC) : (st.wc != 16'h0000 ? st.wc - 16'h0001 : st.wc);
    if (fire_1) begin
      next_st.slow_cnt = st.slow_cnt + 32'h0000_0001;
    end
    if (fire_c) begin
      next_st.cal_cnt = st.cal_cnt + 32'h0000_0001;
    end

    // supply bad: accumulators and pulse timers held at zero
    if (!good) begin
      next_st.acc_s = 48'h0000_0000_0000;
      next_st.acc_c = 48'h0000_0000_0000;
      next_st.w1 = 16'h0000;
      next_st.w2 = 16'h0000;
      next_st.wc = 16'h0000;
      next_st.neg_out = 1'b0;
    end
    next_st.f1 = next_st.w1 != 16'h0000;
    next_st.f2 = next_st.w2 != 16'h0000;
    next_st.cf = next_st.wc != 16'h0000;
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ctrl: CTRL_RST, sup: SUP_LOW, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign apb_rsp = st.rsp;
  assign avg_power_pulse_first = st.f1;
  assign avg_power_pulse_second = st.f2;
  assign calibration_pulse_out = st.cf;
  assign negative_power_flag = st.neg_out;

endmodule

// [tb/pmp_monitor.sv]
`timescale 1ns/1ps
// ----
// pulse output checker
// ----
module pmp_monitor #(
  parameter int unsigned SLOW_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic supply_above_trigger,
  input wire logic avg_power_pulse_first,
  input wire logic avg_power_pulse_second,
  input wire logic calibration_pulse_out,
  input wire logic negative_power_flag
);
  import pmp_pkg::*;
  logic [31:0] lo, hi, w1, w2, wc;
  logic off_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // run lengths; off_q leaves a margin around both supply qualify windows
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo <= '0;
      hi <= '0;
      w1 <= '0;
      w2 <= '0;
      wc <= '0;
      off_q <= 1'h1;
    end else begin
      lo <= supply_above_trigger ? '0 : lo + 32'h1;
      hi <= supply_above_trigger ? hi + 32'h1 : '0;
      w1 <= avg_power_pulse_first ? w1 + 32'h1 : '0;
      w2 <= avg_power_pulse_second ? w2 + 32'h1 : '0;
      wc <= calibration_pulse_out ? wc + 32'h1 : '0;
      off_q <= (lo == 32'h1FE) | (off_q & (hi != 32'h960));
    end
  end
  a_off_slow: assert property (
    off_q |-> !avg_power_pulse_first && !avg_power_pulse_second) else $error("slow pulse off");
  a_off_cal: assert property (
    off_q |-> !calibration_pulse_out && !negative_power_flag) else $error("cal or flag off");
  a_cal_width: assert property (
    wc != 32'h0 && !calibration_pulse_out && lo == 32'h0 |-> wc >= CAL_WIDTH_CYC)
    else $error("cal pulse short");
  a_first_width: assert property (
    w1 != 32'h0 && !avg_power_pulse_first && lo == 32'h0 |-> w1 >= SLOW_WIDTH)
    else $error("first pulse short");
  a_second_width: assert property (
    w2 != 32'h0 && !avg_power_pulse_second && lo == 32'h0 |-> w2 >= SLOW_WIDTH)
    else $error("second pulse short");
  a_first_cause: assert property ($rose(avg_power_pulse_first) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("first pulse unprompted");
  a_cal_cause: assert property ($rose(calibration_pulse_out) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("cal pulse unprompted");
  a_flag_cause: assert property ($rose(negative_power_flag) |->
    $past(sample_valid) || $past(sample_valid, 2)) else $error("flag unprompted");
endmodule

// [tb/pmp_pulse_counter.sv]
`timescale 1ns/1ps
// ----
// far-side pulse counter
// ----
module pmp_pulse_counter (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] pulses,
  output logic [2:0][31:0] cnt
);
  logic [2:0] prev;
  // counts rising edges; a rate is only read as a count over a long window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      cnt <= '0;
    end else begin
      prev <= pulses;
      for (int k = 0; k < 3; k++) begin
        cnt[k] <= cnt[k] + 32'(pulses[k] & ~prev[k]);
      end
    end
  end
endmodule

// [tb/polyphase_power_to_frequency_tb.sv]
`timescale 1ns/1ps
`define chk(n, x, y) begin compares++; if ((x) !== (y)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, x, y); end end
// ----
// bench top
// ----
module polyphase_power_to_frequency_tb;
  import pmp_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic sv = 1'h0;
  logic sup = 1'h1;
  logic c_neg = 1'h0;
  logic p1, p2, pc, nf, e;
  logic [7:0] ph = '0;
  logic [31:0] q, r, s;
  logic [2:0][31:0] cnt;
  pmp_apb_req_s req = '0;
  pmp_apb_rsp_s rsp;
  pmp_sample_s smp = '0;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  pmp_power_to_freq #(.SLOW_WIDTH(8)) pmp_power_to_freq_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .sample_valid(sv), .samples(smp),
    .supply_above_trigger(sup), .avg_power_pulse_first(p1), .avg_power_pulse_second(p2),
    .calibration_pulse_out(pc), .negative_power_flag(nf));
  pmp_pulse_counter pmp_pulse_counter_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .pulses({pc, p2, p1}), .cnt(cnt));

  always #2 ref_clk = ~ref_clk;

  // square wave samples every 4th cycle; slow enough that offset filtering keeps its shape
  always @(posedge ref_clk) begin
    cyc++;
    sv <= (cyc % 4 == 0);
    if (cyc % 4 == 0) ph <= ph + 8'h1;
    // one assignment per edge: currents and volt a/b follow ph, volt c may be inverted
    smp <= {{3{ph[7] ? 16'hC000 : 16'h4000}}, (ph[7] ^ c_neg) ? 16'hC000 : 16'h4000,
            {2{ph[7] ? 16'hC000 : 16'h4000}}};
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one transfer: setup, access, hold until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{1'h1, 1'h0, w, ad, d};
    @(posedge ref_clk);
    req.penable <= 1'h1;
    // pready is looked at on rising edges only; the request stands until it is seen
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (n == 20) error_cnt++;
  endtask

  // calibration crossings over a fixed window after the filters settle
  task automatic cal_rate(output logic [31:0] d);
    repeat (1024) @(posedge ref_clk);
    apb(1'h0, REG_CAL_CNT, '0);
    d = q;
    repeat (4096) @(posedge ref_clk);
    apb(1'h0, REG_CAL_CNT, '0);
    d = q - d;
    wait (ph[6:0] == 7'h7C);
    @(negedge ref_clk);
    `chk("flag neg", 1'h1, nf)
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'h1;
    apb(1'h0, REG_CTRL, '0);
    `chk("ctrl rst", 32'(CTRL_RST), q)
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, REG_CTRL, 32'(2 * k + 1));
      apb(1'h0, REG_CTRL, '0);
      `chk("ctrl sel", 32'(2 * k + 1), q)
    end
    apb(1'h0, 8'h10, '0);
    `chk("unmapped err", 1'h1, e)
    apb(1'h1, REG_CTRL, 32'h1);
    $display("register test done");
    for (int n = 0; n < 20000 && cnt[0] < 32'h2; n++) @(posedge ref_clk);
    apb(1'h0, REG_SLOW_CNT, '0);
    `chk("slow seen", 1'h1, q >= 32'h2)
    `chk("slow count", cnt[0], q)
    r = q;
    `chk("second rate", 1'h1, cnt[1] >= cnt[0] && cnt[1] <= cnt[0] + 32'h1)
    `chk("cal seen", 1'h1, cnt[2] != 32'h0)
    apb(1'h0, REG_CAL_CNT, '0);
    `chk("cal ratio", 1'h1, q >= 128 * r && q <= 129 * (r + 1))
    wait (ph[6:0] == 7'h7C);
    @(negedge ref_clk);
    `chk("flag pos", 1'h0, nf)
    $display("rate test done");
    c_neg <= 1'h1;
    cal_rate(r);
    apb(1'h1, REG_CTRL, 32'h0);
    cal_rate(s);
    `chk("abs sum", 1'h1, s > 2 * r && r != 32'h0)
    apb(1'h1, REG_CTRL, 32'h1);
    c_neg <= 1'h0;
    $display("summing test done");
    sup <= 1'h0;
    repeat (100) @(posedge ref_clk);
    apb(1'h0, REG_STATUS, '0);
    `chk("dip kept", 1'h1, q[0])
    sup <= 1'h1;
    repeat (600) @(posedge ref_clk);
    sup <= 1'h0;
    repeat (1000) @(posedge ref_clk);
    apb(1'h0, REG_STATUS, '0);
    `chk("supply off", 1'h0, q[0])
    r = cnt[0];
    sup <= 1'h1;
    repeat (2900) @(posedge ref_clk);
    `chk("no early pulse", r, cnt[0])
    $display("supply test done");
    tally_and_finish();
  end
endmodule

bind pmp_power_to_freq pmp_monitor #(.SLOW_WIDTH(SLOW_WIDTH)) pmp_monitor_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .sample_valid(sample_valid),
  .supply_above_trigger(supply_above_trigger), .avg_power_pulse_first(avg_power_pulse_first),
  .avg_power_pulse_second(avg_power_pulse_second),
  .calibration_pulse_out(calibration_pulse_out), .negative_power_flag(negative_power_flag));
